// [periph_irq_pkg.sv]
// constants shared by the peripheral interrupt flag and enable bank
// assumes a 32-bit axi4-lite register bus and one system clock
package periph_irq_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_ENABLE_3 = 8'h00;
	localparam logic [7:0] REG_REQUEST_1 = 8'h04;
	localparam logic [7:0] REG_REQUEST_2 = 8'h08;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h10;
	localparam logic [7:0] REG_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] REG_LINK_STATE = 8'h18;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CAPCMP_FIVE_ENABLE_BIT = 6;
	localparam int CAPCMP_FOUR_ENABLE_BIT = 5;
	localparam int CAPCMP_THREE_ENABLE_BIT = 4;
	localparam int TIMER_SIX_MATCH_ENABLE_BIT = 3;
	localparam int TIMER_FOUR_MATCH_ENABLE_BIT = 1;
	localparam int SERIAL_RECEIVE_FLAG_BIT = 5;
	localparam int SERIAL_TRANSMIT_FLAG_BIT = 4;
	localparam int ST_REQUEST_1_BIT = 0;
	localparam int ST_REQUEST_2_BIT = 1;
	localparam int ST_PERIPH_REQ_BIT = 2;
	localparam int STATUS_W = 3;
	localparam int LINK_MASTER_BIT = 0;
	localparam int LINK_GLOBAL_BIT = 1;
	localparam int LINK_REQ_BIT = 2;

	// ------------------------------------------------------------
	// masks and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ENABLE_3_MASK = 8'h7A;
	localparam logic [7:0] REQUEST_1_SW_MASK = 8'hCF;
	localparam logic [7:0] REQUEST_2_MASK = 8'hFD;
	localparam logic [7:0] ENABLE_3_RESET = 8'h00;
	localparam logic [7:0] REQUEST_1_RESET = 8'h00;
	localparam logic [7:0] REQUEST_2_RESET = 8'h00;
	localparam logic [STATUS_W-1:0] IRQ_STATUS_RESET = 3'h0;
	localparam logic [STATUS_W-1:0] IRQ_ENABLE_RESET = 3'h0;

	// ------------------------------------------------------------
	// bus responses
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : periph_irq_pkg

// [periph_irq_flags.sv]
// peripheral interrupt request flags, third enable bank, axi4-lite slave
// assumes event inputs come from logic on REF_CLK; no synchronisers needed
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - no request leaves on PERIPH_IRQ unless the peripheral master enable is set; IRQ can, from status bits 0 and 1.
// - enable-3 bits 6,5,4 enable capture/compare five, four, three.
// - enable-3 bit 3 enables timer six match, bit 1 timer four match.
// - enable-3 bits 7,2,0 ignore writes and read zero.
// - an enable bit of one allows its source, zero blocks it.
// - flags set on their event whatever the enables hold.
// - request-1 holds gate, adc, rx, tx, sync serial, cc1, t2, t1 flags.
// - receive and transmit flags are read-only; other six are writable.
// - request-2 holds osc, cmp2, cmp1, eeprom, collision, lcd, cc2 flags.
// - a flag reads one while pending, zero otherwise.
// - all three registers clear to zero on every reset.
// - request-2 bit 1 ignores writes and reads zero.
module periph_irq_flags #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	// axi4-lite write data
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// axi4-lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	// axi4-lite read data
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// peripheral events
	input wire logic [7:0] REQUEST_1_SET,
	input wire logic [7:0] REQUEST_2_SET,
	input wire logic [7:0] REQUEST_3_FLAGS,
	// enables held elsewhere in the unit
	input wire logic [7:0] ENABLE_1,
	input wire logic [7:0] ENABLE_2,
	input wire logic PERIPHERAL_MASTER_IRQ_ENABLE,
	input wire logic GLOBAL_IRQ_ENABLE,
	// requests out
	output logic PERIPH_IRQ,
	output logic IRQ
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// masked write then event set; set wins over a same-cycle clear
	function automatic logic [7:0] flag_next(
		input logic [7:0] cur,
		input logic wr,
		input logic [7:0] wdata,
		input logic [7:0] wmask,
		input logic [7:0] set
	);
		logic [7:0] kept;
		kept = wr ? ((cur & ~wmask) | (wdata & wmask)) : cur;
		return kept | set;
	endfunction : flag_next

	function automatic logic [7:0] offset_of(input logic [ADDR_W-1:0] addr);
		return {addr[7:2], 2'h0};
	endfunction : offset_of

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] peripheral_irq_enable_3;
	logic [7:0] peripheral_irq_request_1;
	logic [7:0] peripheral_irq_request_2;
	logic [periph_irq_pkg::STATUS_W-1:0] irq_status;
	logic [periph_irq_pkg::STATUS_W-1:0] irq_enable;
	logic [ADDR_W-1:0] aw_addr;
	logic [7:0] w_data;
	logic w_lane;
	logic aw_full;
	logic w_full;

	// ------------------------------------------------------------
	// write channel decode
	// ------------------------------------------------------------
	wire logic aw_take = AWVALID & AWREADY;
	wire logic w_take = WVALID & WREADY;
	wire logic b_done = BVALID & BREADY;
	wire logic do_write = aw_full & w_full;
	wire logic [7:0] w_off = offset_of(aw_addr);
	wire logic w_en = do_write & w_lane;
	wire logic wr_en3 = w_en & (w_off == periph_irq_pkg::REG_ENABLE_3);
	wire logic wr_req1 = w_en & (w_off == periph_irq_pkg::REG_REQUEST_1);
	wire logic wr_req2 = w_en & (w_off == periph_irq_pkg::REG_REQUEST_2);
	wire logic wr_clr = w_en & (w_off == periph_irq_pkg::REG_IRQ_CLEAR);
	wire logic wr_ien = w_en & (w_off == periph_irq_pkg::REG_IRQ_ENABLE);
	wire logic w_mapped = (w_off == periph_irq_pkg::REG_ENABLE_3)
		| (w_off == periph_irq_pkg::REG_REQUEST_1)
		| (w_off == periph_irq_pkg::REG_REQUEST_2)
		| (w_off == periph_irq_pkg::REG_IRQ_STATUS)
		| (w_off == periph_irq_pkg::REG_IRQ_CLEAR)
		| (w_off == periph_irq_pkg::REG_IRQ_ENABLE)
		| (w_off == periph_irq_pkg::REG_LINK_STATE);

	// ------------------------------------------------------------
	// flag and enable next values
	// ------------------------------------------------------------
	// unimplemented enable bits never store anything
	wire logic [7:0] next_enable_3 = wr_en3
		? (w_data & periph_irq_pkg::ENABLE_3_MASK)
		: peripheral_irq_enable_3;
	// receive/transmit follow their peripheral levels only
	wire logic [7:0] rxtx_mask = ~periph_irq_pkg::REQUEST_1_SW_MASK;
	wire logic [7:0] req1_kept = flag_next(peripheral_irq_request_1, wr_req1, w_data,
		periph_irq_pkg::REQUEST_1_SW_MASK, REQUEST_1_SET & ~rxtx_mask);
	wire logic [7:0] next_request_1 = (req1_kept & ~rxtx_mask)
		| (REQUEST_1_SET & rxtx_mask);
	wire logic [7:0] next_request_2 = flag_next(peripheral_irq_request_2, wr_req2, w_data,
		periph_irq_pkg::REQUEST_2_MASK,
		REQUEST_2_SET & periph_irq_pkg::REQUEST_2_MASK);

	// ------------------------------------------------------------
	// peripheral request
	// ------------------------------------------------------------
	// per-source gating: an enable of one passes the flag
	wire logic [7:0] gated_3 = REQUEST_3_FLAGS & peripheral_irq_enable_3;
	wire logic [7:0] gated_1 = peripheral_irq_request_1 & ENABLE_1;
	wire logic [7:0] gated_2 = peripheral_irq_request_2 & ENABLE_2;
	wire logic any_source = (|gated_1) | (|gated_2) | (|gated_3);
	wire logic next_periph_irq = any_source
		& PERIPHERAL_MASTER_IRQ_ENABLE
		& GLOBAL_IRQ_ENABLE;

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	wire logic [7:0] rise_1 = next_request_1 & ~peripheral_irq_request_1;
	wire logic [7:0] rise_2 = next_request_2 & ~peripheral_irq_request_2;
	wire logic [periph_irq_pkg::STATUS_W-1:0] st_set = {
		next_periph_irq & ~PERIPH_IRQ,
		|rise_2,
		|rise_1
	};
	wire logic [periph_irq_pkg::STATUS_W-1:0] st_clr = wr_clr
		? w_data[periph_irq_pkg::STATUS_W-1:0]
		: '0;
	// set wins over a clear in the same cycle
	wire logic [periph_irq_pkg::STATUS_W-1:0] next_status = (irq_status & ~st_clr) | st_set;
	wire logic [periph_irq_pkg::STATUS_W-1:0] next_irq_enable = wr_ien
		? w_data[periph_irq_pkg::STATUS_W-1:0]
		: irq_enable;

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	wire logic ar_take = ARVALID & ARREADY;
	wire logic [7:0] r_off = offset_of(ARADDR);
	wire logic [7:0] link_state = {
		5'h00,
		PERIPH_IRQ,
		GLOBAL_IRQ_ENABLE,
		PERIPHERAL_MASTER_IRQ_ENABLE
	};
	wire logic r_en3 = r_off == periph_irq_pkg::REG_ENABLE_3;
	wire logic r_req1 = r_off == periph_irq_pkg::REG_REQUEST_1;
	wire logic r_req2 = r_off == periph_irq_pkg::REG_REQUEST_2;
	wire logic r_st = r_off == periph_irq_pkg::REG_IRQ_STATUS;
	wire logic r_clr = r_off == periph_irq_pkg::REG_IRQ_CLEAR;
	wire logic r_ien = r_off == periph_irq_pkg::REG_IRQ_ENABLE;
	wire logic r_link = r_off == periph_irq_pkg::REG_LINK_STATE;
	wire logic r_mapped = r_en3 | r_req1 | r_req2 | r_st | r_clr | r_ien | r_link;
	// clear register is write-only and reads zero
	wire logic [7:0] rd_byte =
		({8{r_en3}} & (peripheral_irq_enable_3 & periph_irq_pkg::ENABLE_3_MASK))
		| ({8{r_req1}} & peripheral_irq_request_1)
		| ({8{r_req2}} & (peripheral_irq_request_2 & periph_irq_pkg::REQUEST_2_MASK))
		| ({8{r_st}} & {5'h00, irq_status})
		| ({8{r_ien}} & {5'h00, irq_enable})
		| ({8{r_link}} & link_state);

	// ------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------
	// one write in flight; readies drop until the response is taken
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			AWREADY <= 1'b1;
			aw_full <= 1'b0;
			aw_addr <= '0;
		end else begin
			if (aw_take) begin
				AWREADY <= 1'b0;
				aw_full <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (do_write)
				aw_full <= 1'b0;
			if (b_done)
				AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			WREADY <= 1'b1;
			w_full <= 1'b0;
			w_data <= 8'h00;
			w_lane <= 1'b0;
		end else begin
			if (w_take) begin
				WREADY <= 1'b0;
				w_full <= 1'b1;
				w_data <= WDATA[7:0];
				w_lane <= WSTRB[0];
			end
			if (do_write)
				w_full <= 1'b0;
			if (b_done)
				WREADY <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			BVALID <= 1'b0;
			BRESP <= periph_irq_pkg::RESP_OKAY;
		end else if (do_write) begin
			BVALID <= 1'b1;
			BRESP <= w_mapped ? periph_irq_pkg::RESP_OKAY : periph_irq_pkg::RESP_SLVERR;
		end else if (b_done) begin
			BVALID <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= periph_irq_pkg::RESP_OKAY;
		end else if (ar_take) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RDATA <= {24'h00_0000, rd_byte};
			RRESP <= r_mapped ? periph_irq_pkg::RESP_OKAY : periph_irq_pkg::RESP_SLVERR;
		end else if (RVALID & RREADY) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// every reset kind lands here and clears all three banks
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			peripheral_irq_enable_3 <= periph_irq_pkg::ENABLE_3_RESET;
			peripheral_irq_request_1 <= periph_irq_pkg::REQUEST_1_RESET;
			peripheral_irq_request_2 <= periph_irq_pkg::REQUEST_2_RESET;
		end else begin
			peripheral_irq_enable_3 <= next_enable_3;
			peripheral_irq_request_1 <= next_request_1;
			peripheral_irq_request_2 <= next_request_2;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			irq_status <= periph_irq_pkg::IRQ_STATUS_RESET;
			irq_enable <= periph_irq_pkg::IRQ_ENABLE_RESET;
		end else begin
			irq_status <= next_status;
			irq_enable <= next_irq_enable;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// registered so the core never sees a decode glitch
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			PERIPH_IRQ <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			PERIPH_IRQ <= next_periph_irq;
			IRQ <= |(irq_status & irq_enable);
		end
	end

endmodule : periph_irq_flags

`default_nettype wire

// [periph_irq_flags_assertions.sv]
// checker for the peripheral interrupt flag bank
// sees only the top ports; bound to every instance below
`timescale 1ns/1ps
`default_nettype none
module periph_irq_flags_chk #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// bus handshakes
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic RVALID,
	input wire logic RREADY,
	// events and gating
	input wire logic [7:0] REQUEST_2_SET,
	input wire logic [7:0] ENABLE_2,
	input wire logic PERIPHERAL_MASTER_IRQ_ENABLE,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic PERIPH_IRQ
);
	logic [ADDR_W-1:0] rd_addr;
	wire logic gates = PERIPHERAL_MASTER_IRQ_ENABLE && GLOBAL_IRQ_ENABLE;
	wire logic rd_en3 = rd_addr == ADDR_W'(periph_irq_pkg::REG_ENABLE_3);
	wire logic rd_req2 = rd_addr == ADDR_W'(periph_irq_pkg::REG_REQUEST_2);

	// read data belongs to the address taken at the handshake
	always_ff @(posedge REF_CLK) begin
		if (ARVALID && ARREADY) begin
			rd_addr <= ARADDR;
		end
	end

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	property p_master_gate; !PERIPHERAL_MASTER_IRQ_ENABLE |=> !PERIPH_IRQ; endproperty
	a_master_gate: assert property (p_master_gate) else $error("request with master off");
	property p_global_gate; !GLOBAL_IRQ_ENABLE |=> !PERIPH_IRQ; endproperty
	a_global_gate: assert property (p_global_gate) else $error("request with global off");
	property p_event_irq;
		(REQUEST_2_SET[0] && ENABLE_2[0] && gates) ##1 (ENABLE_2[0] && gates) |=> PERIPH_IRQ;
	endproperty
	a_event_irq: assert property (p_event_irq) else $error("event did not raise request");
	property p_en3_unused; RVALID && rd_en3 |-> !RDATA[7] && !RDATA[2] && !RDATA[0]; endproperty
	a_en3_unused: assert property (p_en3_unused) else $error("unused enable bit set");
	property p_req2_unused; RVALID && rd_req2 |-> !RDATA[1]; endproperty
	a_req2_unused: assert property (p_req2_unused) else $error("unused flag bit set");
	property p_read_answer; ARVALID && ARREADY |=> RVALID && !ARREADY; endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_write_answer;
		AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY && !BVALID ##1 BVALID;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer timing");
	property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");

	c_write: cover property (AWVALID && AWREADY && WVALID && WREADY);
	c_read_stall: cover property (RVALID && !RREADY);
	c_request: cover property ($rose(PERIPH_IRQ));
endmodule : periph_irq_flags_chk

bind periph_irq_flags periph_irq_flags_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// [periph_event_src.sv]
// stand-in for the timers, serial ports, adc and other event sources
// assumes the same clock as the flag bank; bench commands one pulse at a time
`timescale 1ns/1ps
`default_nettype none
module periph_event_src (
	// clock
	input wire logic clk,
	// commands from the bench
	input wire logic fire1,
	input wire logic fire2,
	input wire logic [7:0] pat,
	input wire logic rx,
	input wire logic tx,
	// event lines
	output logic [7:0] set1,
	output logic [7:0] set2
);
	// events are single-cycle pulses; serial pending lines are levels
	always_ff @(posedge clk) begin
		set1 <= {fire1 ? pat[7:6] : 2'b00, rx, tx, fire1 ? pat[3:0] : 4'h0};
		set2 <= fire2 ? pat : 8'h00;
	end
endmodule : periph_event_src
`default_nettype wire

// [tb.sv]
// self-checking bench for the peripheral interrupt flag bank
// assumes the checker is bound and the event source model is compiled
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [7:0] EN3 = periph_irq_pkg::REG_ENABLE_3;
	localparam logic [7:0] RQ1 = periph_irq_pkg::REG_REQUEST_1;
	localparam logic [7:0] RQ2 = periph_irq_pkg::REG_REQUEST_2;
	localparam logic [7:0] STA = periph_irq_pkg::REG_IRQ_STATUS;
	localparam logic [7:0] CLR = periph_irq_pkg::REG_IRQ_CLEAR;
	localparam logic [7:0] IEN = periph_irq_pkg::REG_IRQ_ENABLE;
	localparam logic [7:0] LNK = periph_irq_pkg::REG_LINK_STATE;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, en1 = 8'h00, en2 = 8'h00, flags3 = 8'h00;
	logic [7:0] pat = 8'h00, d;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic mst_en = 1'b0, glb_en = 1'b0, fire1 = 1'b0, fire2 = 1'b0, rx = 1'b0, tx = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid, periph_irq, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] set1, set2;
	logic [33:0] expq[$];
	int failures = 0, compares = 0, cycles = 0, seed = 59244;
	int bits[5] = '{6, 5, 4, 3, 1};

	always #2.5 clk = ~clk;

	periph_irq_flags #(.ADDR_W(8)) dut (.REF_CLK(clk), .RST_N(rst_n), .AWADDR(awaddr),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
		.WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready), .REQUEST_1_SET(set1), .REQUEST_2_SET(set2), .REQUEST_3_FLAGS(flags3),
		.ENABLE_1(en1), .ENABLE_2(en2), .PERIPHERAL_MASTER_IRQ_ENABLE(mst_en),
		.GLOBAL_IRQ_ENABLE(glb_en), .PERIPH_IRQ(periph_irq), .IRQ(irq));
	periph_event_src src (.clk(clk), .fire1(fire1), .fire2(fire2), .pat(pat), .rx(rx),
		.tx(tx), .set1(set1), .set2(set2));

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task summarize;
		if (failures == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	always @(posedge clk) begin
		cycles++;
		if (bvalid && bready) chk({bresp, 32'h0}, expq.pop_front());
		if (rvalid && rready) chk({rresp, rdata}, expq.pop_front());
		if (cycles == 5000) begin
			failures++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// bus and event drivers
	// ------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// ready is raised at random so the slave must hold its answer
	task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = 2'b00);
		expq.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if ($random(seed) & 1) bready <= 1'b1;
		end
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = 2'b00);
		expq.push_back({r, 24'h0, v});
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if ($random(seed) & 1) rready <= 1'b1;
		end
		rready <= 1'b0;
	endtask : rd

	task ev(input logic bank2, input logic [7:0] p);
		pat <= p;
		fire1 <= !bank2;
		fire2 <= bank2;
		@(posedge clk);
		fire1 <= 1'b0;
		fire2 <= 1'b0;
		tick(5);
	endtask : ev

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		tick(16);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 7; i++) rd(8'(i * 4), 8'h00);
		rd(8'h1C, 8'h00, 2'h2);
		wr(8'h1C, 8'h00, 2'h2);
		for (int i = 0; i < 5; i++) begin
			d = (i == 0) ? 8'hFF : 8'($random(seed));
			wr(EN3, d);
			rd(EN3, d & 8'h7A);
		end
		// a write with lane 0 off must leave the register alone
		wstrb <= 4'hE;
		wr(EN3, 8'h00);
		wstrb <= 4'hF;
		rd(EN3, d & 8'h7A);
		wr(RQ2, 8'hFF);
		rd(RQ2, 8'hFD);
		wr(RQ1, 8'hFF);
		rd(RQ1, 8'hCF);
		rx <= 1'b1;
		tick(3);
		rd(RQ1, 8'hEF);
		rx <= 1'b0;
		tx <= 1'b1;
		tick(3);
		rd(RQ1, 8'hDF);
		tx <= 1'b0;
		wr(RQ1, 8'h00);
		wr(RQ2, 8'h00);
		mst_en <= 1'b1;
		glb_en <= 1'b1;
		foreach (bits[i]) begin
			wr(EN3, 8'h01 << bits[i]);
			flags3 <= ~(8'h01 << bits[i]);
			tick(3);
			rd(LNK, 8'h03);
			flags3 <= 8'h01 << bits[i];
			tick(3);
			rd(LNK, 8'h07);
		end
		mst_en <= 1'b0;
		tick(3);
		rd(LNK, 8'h02);
		mst_en <= 1'b1;
		glb_en <= 1'b0;
		tick(3);
		rd(LNK, 8'h01);
		flags3 <= 8'h00;
		mst_en <= 1'b0;
		d = 8'($random(seed));
		ev(1'b1, d);
		rd(RQ2, d & 8'hFD);
		ev(1'b0, d);
		rd(RQ1, d & 8'hCF);
		wr(RQ1, 8'h00);
		wr(RQ2, 8'h00);
		en1 <= 8'h80;
		en2 <= 8'h01;
		mst_en <= 1'b1;
		glb_en <= 1'b1;
		ev(1'b0, 8'h80);
		rd(LNK, 8'h07);
		chk({33'h0, periph_irq}, 34'h1);
		wr(RQ1, 8'h00);
		tick(3);
		rd(LNK, 8'h03);
		ev(1'b1, 8'h01);
		rd(LNK, 8'h07);
		wr(CLR, 8'h07);
		rd(STA, 8'h00);
		rd(CLR, 8'h00);
		wr(IEN, 8'h02);
		chk({33'h0, irq}, 34'h0);
		ev(1'b1, 8'h40);
		chk({33'h0, irq}, 34'h1);
		rd(STA, 8'h02);
		wr(IEN, 8'h01);
		tick(2);
		chk({33'h0, irq}, 34'h0);
		wr(CLR, 8'h02);
		rd(STA, 8'h00);
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(RQ2, 8'h00);
		rd(EN3, 8'h00);
		summarize();
	end
endmodule : tb
`default_nettype wire
